// ---- logic/ext_pin_interrupt_sense.sv ----
/*
 * sense control register and request gating for two external interrupt pins.
 * assumes a single-cycle I/O register port from the processor on mclk, and
 * that the global enable and mask bits come from processor registers.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ext_int_map.svh"

// Functional notes
// [RULE_01] pin one request needs global enable and mask
// [RULE_02] pin zero request needs global enable and mask
// [RULE_03] bits 3:2 select pin one trigger
// [RULE_04] bits 1:0 select pin zero trigger
// [RULE_05] pins synchronised before edge detection
// [RULE_06] pulses over one clock are caught
// [RULE_07] source holds low level until instruction ends
// [RULE_08] register at 0x35/0x55, four bits, resets zero
// [RULE_09] I/O access at offset, data access plus 0x20
// [RULE_10] edges latch pending, low level follows pin
module ext_pin_interrupt_sense
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // external pins
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    // register access
    input wire logic io_space,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // enables from the processor status word and mask register
    input wire logic global_int_enable,
    input wire logic [1:0] ext_irq_mask,
    // interrupt requests and acknowledges, index 0 is pin zero
    input wire logic [1:0] irq_ack,
    output logic [1:0] irq_request,
    output logic [1:0] irq_pending,
    output logic [1:0] pin_level
);
    import ext_int_pkg::*;

    logic [7:0] ext_int_sense_control_ff;
    logic [7:0] nxt_ext_int_sense_control;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [`PIN_COUNT-1:0] raw_req;
    logic [`PIN_COUNT-1:0] pins;
    logic sel;

    function automatic logic addr_match(input logic io, input logic [7:0] a);
        if (io)
            addr_match = (a <= `IO_SPACE_LAST) && (a == `SENSE_CTRL_IO_OFFSET); // RULE_09
        else
            addr_match = (a == `SENSE_CTRL_DATA_ADDR); // RULE_08
    endfunction

    assign sel = addr_match(io_space, reg_addr);
    assign reg_hit = sel & (reg_wr | reg_rd);
    assign pins = {ext_irq_pin_one, ext_irq_pin_zero};

    always_comb
    begin
        nxt_ext_int_sense_control = ext_int_sense_control_ff;
        if (sel && reg_wr)
            nxt_ext_int_sense_control = reg_wdata & `SENSE_CTRL_RW_MASK; // RULE_08
        nxt_rdata = rdata_ff;
        if (sel && reg_rd)
            nxt_rdata = ext_int_sense_control_ff;
        else if (reg_rd)
            nxt_rdata = 8'h00;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ext_int_sense_control_ff <= `SENSE_CTRL_RESET; // RULE_08
            rdata_ff <= 8'h00;
        end
        else
        begin
            ext_int_sense_control_ff <= nxt_ext_int_sense_control;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1)
        begin : g_pin
            // pin zero uses bits 1:0, pin one bits 3:2
            sense_mode_t mode; // RULE_03 RULE_04
            assign mode = sense_mode_t'(ext_int_sense_control_ff[2*gi +: 2]);
            pin_sense_unit u_sense
            (
                .mclk(mclk),
                .nrst(nrst),
                .pin(pins[gi]), // RULE_05 RULE_06
                .mode(mode),
                .ack(irq_ack[gi]),
                .request(raw_req[gi]), // RULE_10 RULE_07
                .level(pin_level[gi])
            );
        end
    endgenerate

    assign irq_pending = raw_req;

    // per-pin gating by the global enable and that pin's own mask bit
    genvar gq;
    generate
        for (gq = 0; gq < `PIN_COUNT; gq = gq + 1)
        begin : g_gate
            assign irq_request[gq] = raw_req[gq] & global_int_enable & ext_irq_mask[gq]; // RULE_01 RULE_02
        end
    endgenerate
endmodule // ext_pin_interrupt_sense

`default_nettype wire

// ---- logic/ext_int_map.svh ----
/*
 * register map and field positions of the external pin interrupt sense block.
 * assumes inclusion by the package and by the design modules.
 */
`ifndef EXT_INT_MAP_SVH
`define EXT_INT_MAP_SVH

`define IO_SPACE_LAST 8'h3F
`define IO_DATA_SPACE_BIAS 8'h20
`define SENSE_CTRL_IO_OFFSET 8'h35
`define SENSE_CTRL_DATA_ADDR 8'h55
`define SENSE_CTRL_RESET 8'h00
`define SENSE_CTRL_RW_MASK 8'h0F
`define PIN0_SENSE_LSB 0
`define PIN1_SENSE_LSB 2
`define PIN_COUNT 2

`endif

// ---- logic/ext_int_pkg.sv ----
/*
 * types shared by the external pin interrupt sense block.
 * assumes ext_int_map.svh is on the include path.
 */
`include "ext_int_map.svh"

package ext_int_pkg;
    typedef enum logic [1:0]
    {
        SENSE_LOW_LEVEL = 2'h0,
        SENSE_ANY_CHANGE = 2'h1,
        SENSE_FALLING = 2'h2,
        SENSE_RISING = 2'h3
    } sense_mode_t;
endpackage

// ---- logic/pin_sense_unit.sv ----
/*
 * one pin's synchroniser, edge detector and pending latch.
 * assumes the pin is asynchronous to mclk and the mode comes from mclk logic.
 */
`timescale 1ns/1ns
`default_nettype none

module pin_sense_unit
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // pin and control
    input wire logic pin,
    input wire ext_int_pkg::sense_mode_t mode,
    input wire logic ack,
    // result
    output logic request,
    output logic level
);
    import ext_int_pkg::*;

    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic pend_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;
    logic nxt_pend;
    logic event_hit;

    always_comb
    begin
        nxt_meta = pin;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
        // detection on registered samples only
        unique case (mode)
            SENSE_ANY_CHANGE: event_hit = sync_ff ^ prev_ff;
            SENSE_FALLING: event_hit = prev_ff & ~sync_ff;
            SENSE_RISING: event_hit = ~prev_ff & sync_ff;
            SENSE_LOW_LEVEL: event_hit = 1'b0;
        endcase
        // new event wins over an acknowledge in the same cycle
        if (event_hit)
            nxt_pend = 1'b1;
        else if (ack || mode == SENSE_LOW_LEVEL)
            nxt_pend = 1'b0;
        else
            nxt_pend = pend_ff;
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
            pend_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
            pend_ff <= nxt_pend;
        end
    end

    assign level = sync_ff;
    assign request = (mode == SENSE_LOW_LEVEL) ? ~sync_ff : pend_ff;
endmodule // pin_sense_unit

`default_nettype wire

// ---- verification/ext_int_properties.sv ----
/* checker for the pin sense block.
   assumes pins idle high through reset. */
`timescale 1ns/1ns
`default_nettype none
module ext_int_properties
(
    // clock, reset, pins
    input wire logic mclk, nrst, ext_irq_pin_zero, ext_irq_pin_one,
    // register port
    input wire logic io_space, reg_wr, reg_rd, reg_hit,
    input wire logic [7:0] reg_addr, reg_rdata,
    // requests
    input wire logic global_int_enable,
    input wire logic [1:0] ext_irq_mask, irq_request, pin_level
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_rd; reg_rd && reg_hit; endsequence
    property p_g0; irq_request[0] |-> ext_irq_mask[0] && global_int_enable; endproperty
    a_g0: assert property (p_g0) else $error("gate 0");
    property p_g1; irq_request[1] |-> ext_irq_mask[1] && global_int_enable; endproperty
    a_g1: assert property (p_g1) else $error("gate 1");
    property p_rd; s_rd |=> reg_rdata[7:4] == 4'h0; endproperty
    a_rd: assert property (p_rd) else $error("upper bits");
    property p_io; (reg_wr || reg_rd) && io_space && reg_addr == 8'h35 |-> reg_hit; endproperty
    a_io: assert property (p_io) else $error("io miss");
    property p_ds; (reg_wr || reg_rd) && !io_space && reg_addr == 8'h55 |-> reg_hit; endproperty
    a_ds: assert property (p_ds) else $error("data miss");
    property p_ur; reg_rd && !reg_hit |=> reg_rdata == 8'h00; endproperty
    a_ur: assert property (p_ur) else $error("unmapped");
    property p_hd; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hd: assert property (p_hd) else $error("hold");
    property p_sy; pin_level == {$past(ext_irq_pin_one, 2), $past(ext_irq_pin_zero, 2)}; endproperty
    a_sy: assert property (p_sy) else $error("sync");
endmodule // ext_int_properties

bind ext_pin_interrupt_sense ext_int_properties chk (.*);
`default_nettype wire

// ---- verification/ext_pin_source.sv ----
/* pin driver model for both pins.
   assumes levels come from the bench. */
`timescale 1ns/1ns
`default_nettype none
module ext_pin_source
(
    input wire logic mclk,
    input wire logic [1:0] lvl,
    output logic [1:0] pins
);
    // whole-cycle pulses, pins follow lvl on each falling edge
    always_ff @(negedge mclk)
        pins <= lvl;
endmodule // ext_pin_source
`default_nettype wire

// ---- verification/ext_pin_interrupt_sense_test.sv ----
/* bench: register access and all sense modes.
   assumes design and pin model compiled first. */
`timescale 1ns/1ns
`default_nettype none
module ext_pin_interrupt_sense_test;
    logic mclk, nrst, io_space, reg_wr, reg_rd, global_int_enable;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] ext_irq_mask, irq_ack, irq_request, lvl, pins, pend;
    int error_cnt = 0;
    int check_count = 0;
    ext_pin_source src (.mclk, .lvl, .pins);
    ext_pin_interrupt_sense dut (.mclk, .nrst, .ext_irq_pin_zero(pins[0]),
        .ext_irq_pin_one(pins[1]), .io_space, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .reg_hit(), .global_int_enable, .ext_irq_mask, .irq_ack, .irq_request,
        .irq_pending(pend), .pin_level());
    task automatic chk(input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic io, wr, input logic [7:0] a, d);
        @(negedge mclk);
        {io_space, reg_addr, reg_wdata, reg_wr, reg_rd} = {io, a, d, wr, !wr};
        @(negedge mclk);
        {reg_wr, reg_rd} = 2'b00;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    initial
    begin
        #40000;
        error_cnt++;
        close_out;
    end
    initial
    begin
        {nrst, io_space, reg_wr, reg_rd, reg_addr, reg_wdata, irq_ack} = '0;
        {global_int_enable, ext_irq_mask, lvl} = 5'h1F;
        repeat (6) @(negedge mclk);
        nrst = 1;
        acc(1, 0, 8'h35, 8'h00);
        chk(reg_rdata, 8'h00);
        acc(1, 1, 8'h35, 8'hFF);
        acc(0, 0, 8'h55, 8'h00);
        chk(reg_rdata, 8'h0F);
        acc(0, 0, 8'h35, 8'h00);
        chk(reg_rdata, 8'h00);
        $display("register test done");
        for (int m = 0; m < 4; m++)
        begin
            acc(1, 1, 8'h35, 8'(m * 3 + 3));
            lvl <= 2'b00;
            repeat (5) @(negedge mclk);
            chk({6'h00, irq_request}, {6'h00, m != 3, m != 0});
            lvl <= 2'b11;
            repeat (5) @(negedge mclk);
            chk({6'h00, irq_request}, {6'h00, m != 0, m != 3});
            {global_int_enable, ext_irq_mask} = m[0] ? 3'b101 : 3'b011;
            #1 chk({6'h00, irq_request}, m[0] ? {7'h00, m != 3} : 8'h00);
            chk({6'h00, pend}, {6'h00, m != 0, m != 3});
            {global_int_enable, ext_irq_mask} = 3'b111;
            irq_ack = 2'b11;
            @(negedge mclk);
            irq_ack = 2'b00;
            @(negedge mclk);
            chk({6'h00, irq_request}, 8'h00);
        end
        $display("mode test done");
        close_out;
    end
endmodule // ext_pin_interrupt_sense_test
`default_nettype wire
